// ### flow_sensor_i2c_command_set_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsic_map.svh"

module flow_sensor_i2c_command_set_tb;
   logic        mclk = 1'h0;
   logic        sys_rst = 1'h1;
   logic [31:0] flowRaw = 32'h0;
   logic        sclOut, sclOe, sdaOut, sdaOe, zeroPulse, sclLow, sdaLow, hung;
   logic [6:0]  slaveAddr;
   wire         sclIn = !(sclLow || sclOe);
   wire         sdaIn = !(sdaLow || sdaOe);
   int          n_fail = 0;
   int          comparisons = 0;
   int          zeroCnt = 0;
   int          sclHeld = 0;

   always #5 mclk = ~mclk;
   always @(posedge mclk) if (zeroPulse === 1'h1) zeroCnt <= zeroCnt + 1;
   always @(posedge mclk) if (sclOe === 1'h1) sclHeld <= sclHeld + 1;

   fsic_core fsic_core_inst (.mclk, .sys_rst, .sclIn, .sclOut, .sclOe, .sdaIn, .sdaOut,
      .sdaOe, .flowRaw, .slaveAddr, .zeroPulse);
   fsic_mstr fsic_mstr_inst (.mclk, .sclIn, .sdaIn, .sclLow, .sdaLow, .hung);

   task automatic conclude;
      $display("failures %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude
   always @(posedge hung)
   begin
      n_fail++;
      conclude();
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         n_fail++;
      end
   endtask : chk
   task automatic wrTx(input logic [6:0] a, input logic [7:0] c, input logic [7:0] g,
                       output logic ok);
      logic k1, k2, k3;
      fsic_mstr_inst.start();
      fsic_mstr_inst.wrByte({a, 1'h0}, k1);
      fsic_mstr_inst.wrByte(c, k2);
      fsic_mstr_inst.wrByte(g, k3);
      fsic_mstr_inst.stop();
      ok = k1 & k2 & k3;
   endtask : wrTx
   task automatic rdTx(input logic [6:0] a, input logic [7:0] c, input int n,
                       output logic ok, output logic [31:0] w);
      logic       x;
      logic [7:0] b;
      w = 32'h0;
      fsic_mstr_inst.start();
      fsic_mstr_inst.wrByte({a, 1'h0}, ok);
      fsic_mstr_inst.wrByte(c, x);
      fsic_mstr_inst.start();
      fsic_mstr_inst.wrByte({a, 1'h1}, x);
      for (int i = 0; i < n; i++)
      begin
         fsic_mstr_inst.rdByte(i < n - 1, b);
         w = {w[23:0], b};
      end
      fsic_mstr_inst.stop();
   endtask : rdTx
   task automatic t_reads;
      logic        ok;
      logic [31:0] w;
      int          h0;
      chk(32'(slaveAddr), 32'h1);
      h0 = sclHeld;
      rdTx(7'h01, 8'h85, 1, ok, w);
      chk(w, 32'h02);
      chk(32'(sclHeld - h0), 32'(3 * `FSIC_STRETCH_CYC));
      rdTx(7'h01, 8'h85, 2, ok, w);
      chk(w, 32'h02ff);
      flowRaw = 32'hfffe1dc0;
      rdTx(7'h01, 8'h83, 4, ok, w);
      chk(w, 32'hfffe1dc0);
   endtask : t_reads
   task automatic t_zero;
      logic        ok;
      logic [31:0] w;
      int          z0;
      z0 = zeroCnt;
      flowRaw = 32'h100;
      wrTx(7'h01, 8'h1c, 8'h01, ok);
      chk(32'(zeroCnt - z0), 32'h0);
      wrTx(7'h01, 8'h1c, 8'h00, ok);
      chk({31'h0, ok}, 32'h1);
      chk(32'(zeroCnt - z0), 32'h1);
      flowRaw = 32'h80;
      rdTx(7'h01, 8'h83, 4, ok, w);
      chk(w, 32'hffffff80);
   endtask : t_zero
   task automatic t_addr;
      logic        ok;
      logic [31:0] w;
      wrTx(7'h01, 8'h05, {7'h2a, 1'h0}, ok);
      chk(32'(slaveAddr), 32'h2a);
      rdTx(7'h01, 8'h85, 1, ok, w);
      chk({31'h0, ok}, 32'h0);
      rdTx(7'h2a, 8'h85, 1, ok, w);
      chk(w, 32'h54);
      fsic_mstr_inst.start();
      fsic_mstr_inst.wrByte(8'h01, ok);
      fsic_mstr_inst.stop();
      chk({31'h0, ok}, 32'h0);
      wrTx(7'h00, 8'h05, 8'h02, ok);
      chk(32'(slaveAddr), 32'h1);
   endtask : t_addr

   initial
   begin
      repeat (3) @(posedge mclk);
      #1;
      sys_rst = 1'h0;
      repeat (4) @(posedge mclk);
      #1;
      t_reads();
      t_zero();
      t_addr();
      conclude();
   end
endmodule : flow_sensor_i2c_command_set_tb

`default_nettype wire

// ### fsic_bus_cond.sv
`timescale 1ns/1ps
`default_nettype none

module fsic_bus_cond (
   input  wire logic   mclk,
   input  wire logic   sys_rst,
   input  wire logic   sclIn,
   input  wire logic   sdaIn,
   fsic_cond_if.det    cond
);

   fsic_pkg::fsic_cond_type c_reg;
   fsic_pkg::fsic_cond_type c_next;

   always_comb
   begin
      c_next         = c_reg;
      c_next.prevScl = sclIn;
      c_next.prevSda = sdaIn;
      // sda edges while scl high
      c_next.startEv = c_reg.prevScl & sclIn & c_reg.prevSda & ~sdaIn;
      c_next.stopEv  = c_reg.prevScl & sclIn & ~c_reg.prevSda & sdaIn;
      c_next.sclRise = ~c_reg.prevScl & sclIn;
      c_next.sclFall = c_reg.prevScl & ~sclIn;
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         c_reg <= '{prevScl: 1'h1, prevSda: 1'h1, default: '0};
      end
      else
      begin
         c_reg <= c_next;
      end
   end

   assign cond.startEv = c_reg.startEv;
   assign cond.stopEv  = c_reg.stopEv;
   assign cond.sclRise = c_reg.sclRise;
   assign cond.sclFall = c_reg.sclFall;

endmodule : fsic_bus_cond

`default_nettype wire

// ### fsic_cond_if.sv
`timescale 1ns/1ps
`default_nettype none

interface fsic_cond_if;
   logic startEv;
   logic stopEv;
   logic sclRise;
   logic sclFall;

   modport det (output startEv, output stopEv, output sclRise, output sclFall);
   modport use_side (input startEv, input stopEv, input sclRise, input sclFall);
endinterface : fsic_cond_if

`default_nettype wire

// ### fsic_core.sv
// Notes on behaviour
// - first written byte after address is the command code
// - command 83h then repeated start read returns four flow bytes
// - flow index is 32 bits, most significant byte sent first
// - negative flow index is two's complement over 32 bits
// - command 85h then read returns the current individual address
// - command 05h plus new address byte, adopted at stop
// - command 1Ch plus 00h acknowledged, zeroing performed
// - answers broadcast 00h for writes only, individual default 01h
// - device may stretch scl after each byte it receives and acks, before the ack; not after bytes it sends
`timescale 1ns/1ps
`default_nettype none
`include "fsic_map.svh"

module fsic_core (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        sclIn,
   output logic             sclOut,
   output logic             sclOe,
   input  wire logic        sdaIn,
   output logic             sdaOut,
   output logic             sdaOe,
   input  wire logic [31:0] flowRaw,
   output logic [6:0]       slaveAddr,
   output logic             zeroPulse
);

   fsic_pkg::fsic_core_type s_reg;
   fsic_pkg::fsic_core_type s_next;

   fsic_cond_if cond ();

   fsic_bus_cond fsic_bus_cond_inst (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .sclIn   (sclIn),
      .sdaIn   (sdaIn),
      .cond    (cond.det)
   );

   // byte to send for a read, by command and position
   function automatic logic [7:0] txByte(
      input logic [7:0]  cmd,
      input logic [2:0]  idx,
      input logic [31:0] word,
      input logic [6:0]  addr
   );
      logic [7:0] b;
      b = `FSIC_FILL_BYTE;
      if (cmd == `FSIC_CMD_READ_FLOW && idx < `FSIC_FLOW_BYTES)
      begin
         case (idx)
            3'h0:    b = word[31:24];
            3'h1:    b = word[23:16];
            3'h2:    b = word[15:8];
            default: b = word[7:0];
         endcase
      end
      else if (cmd == `FSIC_CMD_READ_ADDR && idx == `FSIC_IDX_CMD)
      begin
         b = {addr, 1'h0};
      end
      return b;
   endfunction : txByte

   // starts a clock stretch while the ack is prepared
   function automatic fsic_pkg::fsic_core_type holdScl(input fsic_pkg::fsic_core_type s);
      fsic_pkg::fsic_core_type r;
      r            = s;
      r.sclHold    = 1'h1;
      r.stretchCnt = `FSIC_STRETCH_CYC;
      return r;
   endfunction : holdScl

   always_comb
   begin
      logic [7:0] rxByte;
      logic [7:0] nb;
      rxByte           = s_reg.shift;
      nb               = 8'h00;
      s_next           = s_reg;
      s_next.zeroPulse = 1'h0;

      if (s_reg.sclHold)
      begin
         if (s_reg.stretchCnt <= 4'h1)
         begin
            s_next.sclHold = 1'h0;
         end
         s_next.stretchCnt = s_reg.stretchCnt - 4'h1;
      end

      if (cond.startEv)
      begin
         s_next.state    = fsic_pkg::FSIC_ADDR;
         s_next.bitCnt   = 4'h0;
         s_next.sdaDrive = 1'h0;
         s_next.sclHold  = 1'h0;
      end
      else if (cond.stopEv)
      begin
         s_next.state    = fsic_pkg::FSIC_IDLE;
         s_next.sdaDrive = 1'h0;
         s_next.sclHold  = 1'h0;
         if (s_reg.pendAddrSet)
         begin
            s_next.myAddr = s_reg.pendAddr;
         end
         if (s_reg.pendZero)
         begin
            s_next.offset    = flowRaw;
            s_next.zeroPulse = 1'h1;
         end
         s_next.pendAddrSet = 1'h0;
         s_next.pendZero    = 1'h0;
      end
      else
      begin
         case (s_reg.state)
            fsic_pkg::FSIC_ADDR, fsic_pkg::FSIC_RX:
            begin
               if (cond.sclRise && s_reg.bitCnt < `FSIC_BITS_PER_BYTE)
               begin
                  s_next.shift  = {s_reg.shift[6:0], sdaIn};
                  s_next.bitCnt = s_reg.bitCnt + 4'h1;
               end
               else if (cond.sclFall && s_reg.bitCnt == `FSIC_BITS_PER_BYTE)
               begin
                  if (s_reg.state == fsic_pkg::FSIC_ADDR)
                  begin
                     if (rxByte[7:1] == s_reg.myAddr ||
                         (rxByte[7:1] == `FSIC_ADDR_BCAST && !rxByte[0]))
                     begin
                        s_next          = holdScl(s_next);
                        s_next.state    = fsic_pkg::FSIC_ADDR_ACK;
                        s_next.sdaDrive = 1'h1;
                        s_next.isRead   = rxByte[0];
                        s_next.byteIdx  = `FSIC_IDX_CMD;
                        s_next.txIdx    = 3'h0;
                        s_next.txWord   = flowRaw - s_reg.offset;
                     end
                     else
                     begin
                        s_next.state = fsic_pkg::FSIC_IGNORE;
                     end
                  end
                  else
                  begin
                     s_next          = holdScl(s_next);
                     s_next.state    = fsic_pkg::FSIC_RX_ACK;
                     s_next.sdaDrive = 1'h1;
                     if (s_reg.byteIdx == `FSIC_IDX_CMD)
                     begin
                        s_next.cmd         = rxByte;
                        s_next.pendAddrSet = 1'h0;
                        s_next.pendZero    = 1'h0;
                     end
                     else if (s_reg.byteIdx == `FSIC_IDX_ARG)
                     begin
                        if (s_reg.cmd == `FSIC_CMD_WRITE_ADDR)
                        begin
                           if (rxByte[7:1] != `FSIC_ADDR_BCAST)
                           begin
                              s_next.pendAddr    = rxByte[7:1];
                              s_next.pendAddrSet = 1'h1;
                           end
                        end
                        else if (s_reg.cmd == `FSIC_CMD_AUTO_ZERO &&
                                 rxByte == `FSIC_ZERO_ARG)
                        begin
                           s_next.pendZero = 1'h1;
                        end
                     end
                     if (s_reg.byteIdx != `FSIC_IDX_SAT)
                     begin
                        s_next.byteIdx = s_reg.byteIdx + 3'h1;
                     end
                  end
               end
            end
            fsic_pkg::FSIC_ADDR_ACK, fsic_pkg::FSIC_RX_ACK:
            begin
               if (cond.sclFall)
               begin
                  s_next.bitCnt = 4'h0;
                  if (s_reg.state == fsic_pkg::FSIC_ADDR_ACK && s_reg.isRead)
                  begin
                     nb              = txByte(s_reg.cmd, 3'h0, s_reg.txWord, s_reg.myAddr);
                     s_next.shift    = nb;
                     s_next.sdaDrive = ~nb[7];
                     s_next.txIdx    = 3'h1;
                     s_next.state    = fsic_pkg::FSIC_TX;
                  end
                  else
                  begin
                     s_next.sdaDrive = 1'h0;
                     s_next.state    = fsic_pkg::FSIC_RX;
                  end
               end
            end
            fsic_pkg::FSIC_TX:
            begin
               if (cond.sclRise)
               begin
                  s_next.bitCnt = s_reg.bitCnt + 4'h1;
               end
               else if (cond.sclFall)
               begin
                  if (s_reg.bitCnt == `FSIC_BITS_PER_BYTE)
                  begin
                     s_next.sdaDrive = 1'h0;
                     s_next.state    = fsic_pkg::FSIC_TX_ACK;
                  end
                  else
                  begin
                     s_next.shift    = {s_reg.shift[6:0], 1'h1};
                     s_next.sdaDrive = ~s_reg.shift[6];
                  end
               end
            end
            fsic_pkg::FSIC_TX_ACK:
            begin
               if (cond.sclRise)
               begin
                  s_next.masterAck = ~sdaIn;
               end
               else if (cond.sclFall)
               begin
                  if (s_reg.masterAck)
                  begin
                     nb              = txByte(s_reg.cmd, s_reg.txIdx, s_reg.txWord,
                                              s_reg.myAddr);
                     s_next.shift    = nb;
                     s_next.sdaDrive = ~nb[7];
                     s_next.bitCnt   = 4'h0;
                     s_next.state    = fsic_pkg::FSIC_TX;
                     if (s_reg.txIdx != 3'h7)
                     begin
                        s_next.txIdx = s_reg.txIdx + 3'h1;
                     end
                  end
                  else
                  begin
                     s_next.state = fsic_pkg::FSIC_IGNORE;
                  end
               end
            end
            default:
            begin
               s_next.sdaDrive = 1'h0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         s_reg <= '{state: fsic_pkg::FSIC_IDLE, myAddr: `FSIC_ADDR_DEFAULT, default: '0};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign sclOut    = 1'h0;
   assign sclOe     = s_reg.sclHold;
   assign sdaOut    = 1'h0;
   assign sdaOe     = s_reg.sdaDrive;
   assign slaveAddr = s_reg.myAddr;
   assign zeroPulse = s_reg.zeroPulse;

endmodule : fsic_core

`default_nettype wire

// ### fsic_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module fsic_core_asserts (
   input wire logic        mclk,
   input wire logic        sys_rst,
   input wire logic        sclIn,
   input wire logic        sclOut,
   input wire logic        sclOe,
   input wire logic        sdaIn,
   input wire logic        sdaOut,
   input wire logic        sdaOe,
   input wire logic [31:0] flowRaw,
   input wire logic [6:0]  slaveAddr,
   input wire logic        zeroPulse
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   sequence s_stretch;
      sclOe [*4] ##1 !sclOe;
   endsequence
   sequence s_idle;
      sclIn && sdaIn;
   endsequence

   a_reset_addr_default: assert property ($fell(sys_rst) |-> slaveAddr == 7'h01 && !sdaOe)
      else $error("bad state after reset");
   a_stretch_len: assert property ($rose(sclOe) |-> s_stretch)
      else $error("stretch length wrong");
   a_stretch_ack: assert property ($rose(sclOe) |-> sdaOe && !sclIn)
      else $error("stretch without ack");
   a_open_drain: assert property (sclOut == 1'h0 && sdaOut == 1'h0)
      else $error("pin drives high");
   a_zero_one_pulse: assert property (zeroPulse |=> !zeroPulse)
      else $error("zero pulse too long");
   a_zero_at_stop: assert property (zeroPulse |-> s_idle)
      else $error("zero outside stop");
   a_addr_at_stop: assert property ($changed(slaveAddr) |-> s_idle ##0 slaveAddr != 7'h00)
      else $error("address change bad");
   a_sda_scl_low: assert property ($changed(sdaOe) |-> !sclIn)
      else $error("sda moved with scl high");
   a_drive_bounded: assert property (sdaOe |-> ##[1:400] !sdaOe)
      else $error("sda held too long");
endmodule : fsic_core_asserts

bind fsic_core fsic_core_asserts fsic_core_asserts_inst (.mclk, .sys_rst, .sclIn, .sclOut,
   .sclOe, .sdaIn, .sdaOut, .sdaOe, .flowRaw, .slaveAddr, .zeroPulse);

`default_nettype wire

// ### fsic_map.svh
`ifndef FSIC_MAP_SVH
`define FSIC_MAP_SVH

// command codes
`define FSIC_CMD_READ_FLOW  8'h83
`define FSIC_CMD_READ_ADDR  8'h85
`define FSIC_CMD_WRITE_ADDR 8'h05
`define FSIC_CMD_AUTO_ZERO  8'h1c
`define FSIC_ZERO_ARG       8'h00

// addresses
`define FSIC_ADDR_BCAST     7'h00
`define FSIC_ADDR_DEFAULT   7'h01

// bit and byte counts
`define FSIC_BITS_PER_BYTE  4'h8
`define FSIC_FLOW_BYTES     3'h4
`define FSIC_IDX_CMD        3'h0
`define FSIC_IDX_ARG        3'h1
`define FSIC_IDX_SAT        3'h2

// clock stretch length in mclk cycles
`define FSIC_STRETCH_CYC    4'h4

// idle bus filler byte
`define FSIC_FILL_BYTE      8'hff

`endif

// ### fsic_mstr.sv
`timescale 1ns/1ps
`default_nettype none

module fsic_mstr (
   input  wire logic mclk,
   input  wire logic sclIn,
   input  wire logic sdaIn,
   output logic      sclLow,
   output logic      sdaLow,
   output logic      hung
);
   initial
   begin
      sclLow = 1'h0;
      sdaLow = 1'h0;
      hung = 1'h0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   task automatic sclUp;
      int i;
      sclLow = 1'h0;
      i = 0;
      tick(1);
      while (sclIn !== 1'h1 && i < 200)
      begin
         tick(1);
         i++;
      end
      if (i >= 200) hung = 1'h1;
   endtask : sclUp
   task automatic start;
      sdaLow = 1'h0;
      tick(6);
      sclUp();
      tick(12);
      sdaLow = 1'h1;
      tick(12);
      sclLow = 1'h1;
      tick(6);
   endtask : start
   task automatic stop;
      sdaLow = 1'h1;
      tick(6);
      sclUp();
      tick(12);
      sdaLow = 1'h0;
      tick(12);
   endtask : stop
   task automatic bitIo(input logic b, output logic r);
      sdaLow = !b;
      tick(6);
      sclUp();
      tick(6);
      r = sdaIn;
      tick(6);
      sclLow = 1'h1;
      tick(6);
   endtask : bitIo
   task automatic wrByte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitIo(b[i], r);
      bitIo(1'h1, r);
      ack = !r;
   endtask : wrByte
   task automatic rdByte(input logic mAck, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bitIo(1'h1, b[i]);
      bitIo(!mAck, r);
   endtask : rdByte
endmodule : fsic_mstr

`default_nettype wire

// ### fsic_pkg.sv
`default_nettype none

package fsic_pkg;

   typedef enum logic [2:0] {
      FSIC_IDLE     = 3'h0,
      FSIC_ADDR     = 3'h1,
      FSIC_ADDR_ACK = 3'h3,
      FSIC_RX       = 3'h2,
      FSIC_RX_ACK   = 3'h6,
      FSIC_TX       = 3'h7,
      FSIC_TX_ACK   = 3'h5,
      FSIC_IGNORE   = 3'h4
   } fsic_state_type;

   typedef struct packed {
      logic prevScl;
      logic prevSda;
      logic startEv;
      logic stopEv;
      logic sclRise;
      logic sclFall;
   } fsic_cond_type;

   typedef struct packed {
      fsic_state_type state;
      logic [3:0]     bitCnt;
      logic [7:0]     shift;
      logic [7:0]     cmd;
      logic [2:0]     byteIdx;
      logic [2:0]     txIdx;
      logic           isRead;
      logic           masterAck;
      logic [6:0]     myAddr;
      logic [6:0]     pendAddr;
      logic           pendAddrSet;
      logic           pendZero;
      logic [31:0]    offset;
      logic [31:0]    txWord;
      logic           sdaDrive;
      logic           sclHold;
      logic [3:0]     stretchCnt;
      logic           zeroPulse;
   } fsic_core_type;

endpackage : fsic_pkg

`default_nettype wire
